// File: logic/dual_rail_power_sequencer.sv
// Sequencing, boot code latch, power good and register slave of a dual rail controller.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module dual_rail_power_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int VID_READY_COUNT = VID_READY_CYCLES
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic BIAS_ABOVE_UVLO,
  input wire logic DRIVER_SUPPLY_OK,
  input wire logic ENABLE_IN,
  input wire logic PLATFORM_POWER_OK,
  input wire logic SERIAL_VID_CLOCK,
  input wire logic SERIAL_VID_DATA,
  input wire trip_t CORE_TRIP,
  input wire trip_t NB_TRIP,
  input wire logic CORE_ABOVE_PG,
  input wire logic NB_ABOVE_PG,
  input wire logic CORE_SENSE_LOW,
  input wire logic NB_SENSE_LOW,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [11:0] CORE_REF_MV,
  output logic [11:0] NB_REF_MV,
  output logic CORE_SWITCH_EN,
  output logic NB_SWITCH_EN,
  output logic FORCE_CCM,
  output logic SERIAL_VID_RUN,
  output logic VID_TRANSITION_DONE,
  output logic CORE_POWER_GOOD_O,
  output logic CORE_POWER_GOOD_OE_N,
  output logic NB_POWER_GOOD_O,
  output logic NB_POWER_GOOD_OE_N,
  output logic TELEMETRY_LINE_O,
  output logic TELEMETRY_LINE_OE_N
);

  // ****************************************
  // Power ready and input synchronisers
  // ****************************************
  logic power_ready;
  logic rst_int;
  logic en_meta, en_sync, en_prev;
  logic pok_meta, pok_sync, pok_prev;
  logic en_rise, pok_rise, pok_fall;

  assign power_ready = BIAS_ABOVE_UVLO & DRIVER_SUPPLY_OK;
  // Losing power-ready resets all but the register slave, which only RST clears.
  assign rst_int = RST | ~power_ready;

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_prev <= 1'b0;
      pok_meta <= 1'b0;
      pok_sync <= 1'b0;
      pok_prev <= 1'b0;
    end
    else
    begin
      en_meta <= ENABLE_IN;
      en_sync <= en_meta;
      en_prev <= en_sync;
      pok_meta <= PLATFORM_POWER_OK;
      pok_sync <= pok_meta;
      pok_prev <= pok_sync;
    end
  end

  assign en_rise = en_sync & ~en_prev;
  assign pok_rise = pok_sync & ~pok_prev;
  assign pok_fall = ~pok_sync & pok_prev;

  // ****************************************
  // Sequencer state
  // ****************************************
  seq_state_t state, next_state;
  logic [11:0] boot_mv;
  logic [1:0] boot_code;
  logic bad_order;
  logic [11:0] core_target, nb_target;
  logic step_tick;
  logic core_at, nb_at;

  assign core_at = CORE_REF_MV == core_target;
  assign nb_at = NB_REF_MV == nb_target;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (en_rise && !pok_sync)
          next_state = ST_START;
      ST_START:
        if (!en_sync)
          next_state = ST_STOP;
        else if (core_at && nb_at)
          next_state = ST_RUN;
      ST_RUN:
        if (!en_sync)
          next_state = ST_STOP;
      ST_STOP:
        if (en_rise && !pok_sync)
          next_state = ST_START;
        else if (!CORE_SWITCH_EN && !NB_SWITCH_EN)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // The code is relatched on every enable rise and cleared by RST or power-ready loss.
  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      boot_code <= 2'b00;
      bad_order <= 1'b0;
    end
    else if (en_rise)
    begin
      boot_code <= {SERIAL_VID_CLOCK, SERIAL_VID_DATA};
      bad_order <= pok_sync;
    end
  end

  always_comb
  begin
    case (boot_code)
      2'b00: boot_mv = BOOT_MV_00;
      2'b01: boot_mv = BOOT_MV_01;
      2'b10: boot_mv = BOOT_MV_10;
      2'b11: boot_mv = BOOT_MV_11;
      default: boot_mv = BOOT_MV_00;
    endcase
  end

  // ****************************************
  // Command interface gating
  // ****************************************
  logic [$clog2(VID_READY_COUNT + 1)-1:0] ready_cnt;
  logic vid_ready;
  logic pok_after_en;

  // Counts from enable; a new enable restarts the wait.
  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || !en_sync)
      ready_cnt <= '0;
    else if (!vid_ready)
      ready_cnt <= ready_cnt + 1'b1;
  end
  assign vid_ready = ready_cnt == ($clog2(VID_READY_COUNT + 1))'(VID_READY_COUNT);

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || !en_sync)
      pok_after_en <= 1'b0;
    else if (pok_rise && !bad_order)
      pok_after_en <= 1'b1;
  end

  assign SERIAL_VID_RUN = pok_after_en & pok_sync & vid_ready & (state == ST_RUN);

  // ****************************************
  // Register slave
  // ****************************************
  bus_req_t req;
  logic [31:0] command;
  logic cmd_fire;
  logic core_tripped, nb_tripped;

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      req <= '0;
    else if (HREADY)
      req <= '{valid: HSEL & HTRANS[1], write: HWRITE, addr: HADDR[7:0]};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      HRDATA <= 32'h0000_0000;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
      case (HADDR[7:0])
        ADDR_STATUS:
          HRDATA <= {16'h0000, state, 2'b00, bad_order, SERIAL_VID_RUN,
                     core_tripped, nb_tripped, pok_sync, en_sync, 2'b00, boot_code};
        ADDR_COMMAND: HRDATA <= command;
        ADDR_REFS: HRDATA <= {4'h0, NB_REF_MV, 4'h0, CORE_REF_MV};
        default: HRDATA <= 32'h0000_0000;
      endcase
  end

  // Commands arriving while the interface is stopped are still stored in command but never reach the targets.
  assign cmd_fire = req.valid && req.write && (req.addr == ADDR_COMMAND) && SERIAL_VID_RUN;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      command <= COMMAND_RESET;
    else if (req.valid && req.write && req.addr == ADDR_COMMAND)
      command <= HWDATA;
  end

  // ****************************************
  // Reference ramps
  // ****************************************
  logic [$clog2(STEP_CYCLES)-1:0] step_cnt;
  logic core_pend, nb_pend;

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || step_tick)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + 1'b1;
  end
  // One millivolt per tick gives the soft-start slew rate.
  assign step_tick = step_cnt == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1);

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      core_target <= ZERO_MV;
      nb_target <= ZERO_MV;
    end
    else if (next_state == ST_START || state == ST_START || (state == ST_RUN && pok_fall))
    begin
      core_target <= boot_mv;
      nb_target <= boot_mv;
    end
    else if (state == ST_STOP || next_state == ST_STOP)
    begin
      core_target <= ZERO_MV;
      nb_target <= ZERO_MV;
    end
    else if (cmd_fire)
    begin
      if (HWDATA[CMD_CORE_BIT])
        core_target <= HWDATA[11:0];
      if (HWDATA[CMD_NB_BIT])
        nb_target <= HWDATA[11:0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      CORE_REF_MV <= ZERO_MV;
      NB_REF_MV <= ZERO_MV;
    end
    else if (step_tick)
    begin
      if (CORE_REF_MV < core_target)
        CORE_REF_MV <= CORE_REF_MV + 12'h001;
      else if (CORE_REF_MV > core_target)
        CORE_REF_MV <= CORE_REF_MV - 12'h001;
      if (NB_REF_MV < nb_target)
        NB_REF_MV <= NB_REF_MV + 12'h001;
      else if (NB_REF_MV > nb_target)
        NB_REF_MV <= NB_REF_MV - 12'h001;
    end
  end

  // A new command wins over the completion of the previous one.
  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || state != ST_RUN || pok_fall)
    begin
      core_pend <= 1'b0;
      nb_pend <= 1'b0;
      VID_TRANSITION_DONE <= 1'b0;
    end
    else
    begin
      core_pend <= (cmd_fire && HWDATA[CMD_CORE_BIT]) || (core_pend && !core_at);
      nb_pend <= (cmd_fire && HWDATA[CMD_NB_BIT]) || (nb_pend && !nb_at);
      VID_TRANSITION_DONE <= !cmd_fire && (core_pend || nb_pend)
                             && (!core_pend || core_at) && (!nb_pend || nb_at);
    end
  end

  // ****************************************
  // Switching and conduction mode
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      CORE_SWITCH_EN <= 1'b0;
      NB_SWITCH_EN <= 1'b0;
    end
    else if (next_state == ST_START)
    begin
      CORE_SWITCH_EN <= 1'b1;
      NB_SWITCH_EN <= 1'b1;
    end
    else if (state == ST_STOP)
    begin
      if (CORE_SENSE_LOW && CORE_REF_MV == ZERO_MV)
        CORE_SWITCH_EN <= 1'b0;
      if (NB_SENSE_LOW && NB_REF_MV == ZERO_MV)
        NB_SWITCH_EN <= 1'b0;
    end
  end

  // Continuous conduction is kept for every ramp the sequencer makes itself.
  assign FORCE_CCM = CORE_SWITCH_EN | NB_SWITCH_EN;

  // ****************************************
  // Protection latches and power good
  // ****************************************
  trip_t core_latch, nb_latch;
  logic [$clog2(CROSS_DELAY_CYCLES + 1)-1:0] core_x_cnt, nb_x_cnt;
  logic [$clog2(PG_DELAY_CYCLES + 1)-1:0] pg_cnt;
  logic pg_delay_done, core_pg, nb_pg, core_cross, nb_cross;

  // Enable is not in this reset path, so a low enable keeps the latches.
  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      core_latch <= '0;
      nb_latch <= '0;
    end
    else
    begin
      core_latch <= core_latch | CORE_TRIP;
      nb_latch <= nb_latch | NB_TRIP;
    end
  end
  assign core_tripped = |core_latch;
  assign nb_tripped = |nb_latch;

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || !core_tripped)
      core_x_cnt <= '0;
    else if (!core_cross)
      core_x_cnt <= core_x_cnt + 1'b1;
    if (rst_int || !nb_tripped)
      nb_x_cnt <= '0;
    else if (!nb_cross)
      nb_x_cnt <= nb_x_cnt + 1'b1;
  end
  assign core_cross = core_x_cnt == ($clog2(CROSS_DELAY_CYCLES + 1))'(CROSS_DELAY_CYCLES);
  assign nb_cross = nb_x_cnt == ($clog2(CROSS_DELAY_CYCLES + 1))'(CROSS_DELAY_CYCLES);

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int || state != ST_RUN || !CORE_ABOVE_PG || !NB_ABOVE_PG)
      pg_cnt <= '0;
    else if (!pg_delay_done)
      pg_cnt <= pg_cnt + 1'b1;
  end
  assign pg_delay_done = pg_cnt == ($clog2(PG_DELAY_CYCLES + 1))'(PG_DELAY_CYCLES);

  always_ff @(posedge REF_CLK)
  begin
    if (rst_int)
    begin
      core_pg <= 1'b0;
      nb_pg <= 1'b0;
    end
    else
    begin
      core_pg <= (core_pg || pg_delay_done) && en_sync && ENABLE_IN && state == ST_RUN
                 && !core_tripped && !(|CORE_TRIP) && !nb_cross;
      nb_pg <= (nb_pg || pg_delay_done) && en_sync && ENABLE_IN && state == ST_RUN
               && !nb_tripped && !(|NB_TRIP) && !core_cross;
    end
  end

  // Open drain: the pin is pulled low while the enable is low.
  assign CORE_POWER_GOOD_O = 1'b0;
  assign NB_POWER_GOOD_O = 1'b0;
  assign CORE_POWER_GOOD_OE_N = core_pg;
  assign NB_POWER_GOOD_OE_N = nb_pg;

  // The telemetry serialiser is outside; the line is held high when it must not run, except in ST_OFF where it is released.
  assign TELEMETRY_LINE_O = 1'b1;
  assign TELEMETRY_LINE_OE_N = SERIAL_VID_RUN | (state == ST_OFF);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (rst_int);

  a_pg_low_start: assert property (
    state != ST_RUN |-> CORE_POWER_GOOD_OE_N == 1'b0 && NB_POWER_GOOD_OE_N == 1'b0)
    else $error("power good released outside run");
  a_pg_enable_loss: assert property (
    $fell(en_sync) |=> !CORE_POWER_GOOD_OE_N && !NB_POWER_GOOD_OE_N && state == ST_STOP)
    else $error("power good not dropped on enable loss");
  a_pg_delay: assert property (
    $rose(CORE_POWER_GOOD_OE_N)
    |-> $past(pg_cnt) == ($clog2(PG_DELAY_CYCLES + 1))'(PG_DELAY_CYCLES))
    else $error("power good rose without full delay");
  a_cross_trip: assert property (
    $rose(core_tripped) |-> ##126 !NB_POWER_GOOD_OE_N)
    else $error("other rail power good not pulled low");
  a_trip_own: assert property (
    core_tripped |-> !CORE_POWER_GOOD_OE_N)
    else $error("power good high with core trip latched");
  a_latch_hold: assert property (
    core_tripped |=> core_tripped)
    else $error("protection latch cleared without reset");
  a_boot_latch: assert property (
    en_rise |=> boot_code == $past({SERIAL_VID_CLOCK, SERIAL_VID_DATA}))
    else $error("boot code not latched");
  a_bad_order: assert property (
    en_rise && pok_sync |=> state != ST_START)
    else $error("soft-start after wrong order");
  a_ramp_rate: assert property (
    CORE_REF_MV != $past(CORE_REF_MV) |=> CORE_REF_MV == $past(CORE_REF_MV) [*7])
    else $error("reference stepped too fast");
  a_pok_loss: assert property (
    state == ST_RUN && pok_fall |=> !SERIAL_VID_RUN && core_target == boot_mv)
    else $error("power-ok loss not handled");
  a_telemetry_high: assert property (
    state != ST_OFF && !pok_sync |-> !TELEMETRY_LINE_OE_N && TELEMETRY_LINE_O)
    else $error("telemetry line not driven high");
  a_cmd_gate: assert property (
    SERIAL_VID_RUN |-> pok_sync && vid_ready)
    else $error("interface ran without power-ok");

  c_start_run: cover property (state == ST_START ##1 state == ST_RUN);
  c_pg_up: cover property ($rose(CORE_POWER_GOOD_OE_N));
  c_done: cover property (VID_TRANSITION_DONE);
  c_stop_off: cover property (state == ST_STOP ##1 state == ST_OFF);

endmodule

// File: logic/pwr_seq_pkg.sv
// Shared constants and types of the dual rail power sequencer.
package pwr_seq_pkg;
  localparam int CLK_MHZ = 25;
  localparam int SLEW_MV_PER_US = 3;
  localparam int STEP_CYCLES = CLK_MHZ / SLEW_MV_PER_US;
  localparam int PG_DELAY_US = 100;
  localparam int PG_DELAY_CYCLES = PG_DELAY_US * CLK_MHZ;
  localparam int CROSS_DELAY_US = 5;
  localparam int CROSS_DELAY_CYCLES = CROSS_DELAY_US * CLK_MHZ;
  localparam int VID_READY_MS = 2;
  localparam int VID_READY_CYCLES = VID_READY_MS * 1000 * CLK_MHZ;
  localparam logic [11:0] BOOT_MV_00 = 12'h044C;
  localparam logic [11:0] BOOT_MV_01 = 12'h03E8;
  localparam logic [11:0] BOOT_MV_10 = 12'h0384;
  localparam logic [11:0] BOOT_MV_11 = 12'h0320;
  localparam logic [11:0] ZERO_MV = 12'h0000;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_REFS = 8'h08;
  localparam int CMD_CORE_BIT = 16;
  localparam int CMD_NB_BIT = 17;
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_START = 4'b0010,
    ST_RUN = 4'b0100,
    ST_STOP = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
  } trip_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_req_t;
endpackage

// File: verification/platform_model.sv
// Platform, host and rail model facing the power sequencer.
`timescale 1ns/1ps
module platform_model
  import pwr_seq_pkg::*;
(
  input wire logic clk,
  input wire logic [11:0] core_ref,
  input wire logic [11:0] nb_ref,
  output logic en,
  output logic pok,
  output logic serial_vid_clock,
  output logic serial_vid_data,
  output logic core_above,
  output logic nb_above,
  output logic core_low,
  output logic nb_low
);
  int boot_mv = 1100;
  initial
  begin
    en = 1'b0;
    pok = 1'b0;
    serial_vid_clock = 1'b0;
    serial_vid_data = 1'b0;
  end
  // ****************
  // Rails
  // ****************
  // Ideal rails follow their references, so no droop hides a late threshold.
  assign core_above = (int'(core_ref) + 300 >= boot_mv);
  assign nb_above = (int'(nb_ref) + 300 >= boot_mv);
  assign core_low = (core_ref < 12'h00C8);
  assign nb_low = (nb_ref < 12'h00C8);
  task power_on(input logic [1:0] code);
    @(posedge clk);
    serial_vid_clock <= code[1];
    serial_vid_data <= code[0];
    boot_mv = 1100 - 100 * code;
    @(posedge clk);
    en <= 1'b1;
    repeat (6) @(posedge clk);
    // No frames follow, so the pins stand still at an idle pattern unlike the code.
    serial_vid_clock <= ~code[1];
    serial_vid_data <= ~code[0];
  endtask
  task power_off;
    @(posedge clk);
    en <= 1'b0;
  endtask
  task set_pok(input logic v);
    @(posedge clk);
    pok <= v;
  endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench of the dual rail power sequencer.
`timescale 1ns/1ps
module tb_top
  import pwr_seq_pkg::*;
;
  localparam int F_RUN = 0;
  localparam int F_DONE = 1;
  localparam int F_CPG = 2;
  localparam int F_NPG = 3;
  localparam int F_CSW = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bias_ok = 1'b1;
  logic drv_ok = 1'b1;
  logic en, pok, serial_vid_clock, serial_vid_data, core_above, nb_above, core_low, nb_low;
  trip_t core_trip = '0;
  trip_t nb_trip = '0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, core_sw, nb_sw, ccm, vid_run, vid_done;
  logic core_pg_o, core_pg_oe_n, nb_pg_o, nb_pg_oe_n, tel_o, tel_oe_n;
  logic [11:0] core_ref, nb_ref;
  logic [4:0] flags;
  int fail_count = 0;
  int cmp_count = 0;
  int boot, n, tgt, code;
  always #20 clk = ~clk;
  assign flags = {core_sw | nb_sw, nb_pg_oe_n, core_pg_oe_n, vid_done, vid_run};
  platform_model plat_i (.clk(clk), .core_ref(core_ref), .nb_ref(nb_ref), .en(en), .pok(pok),
    .serial_vid_clock(serial_vid_clock), .serial_vid_data(serial_vid_data), .core_above(core_above), .nb_above(nb_above), .core_low(core_low),
    .nb_low(nb_low));
  dual_rail_power_sequencer #(.VID_READY_COUNT(50)) dual_rail_power_sequencer_i (
    .REF_CLK(clk), .RST(rst), .BIAS_ABOVE_UVLO(bias_ok), .DRIVER_SUPPLY_OK(drv_ok),
    .ENABLE_IN(en), .PLATFORM_POWER_OK(pok), .SERIAL_VID_CLOCK(serial_vid_clock), .SERIAL_VID_DATA(serial_vid_data),
    .CORE_TRIP(core_trip), .NB_TRIP(nb_trip), .CORE_ABOVE_PG(core_above),
    .NB_ABOVE_PG(nb_above), .CORE_SENSE_LOW(core_low), .NB_SENSE_LOW(nb_low), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CORE_REF_MV(core_ref), .NB_REF_MV(nb_ref), .CORE_SWITCH_EN(core_sw),
    .NB_SWITCH_EN(nb_sw), .FORCE_CCM(ccm), .SERIAL_VID_RUN(vid_run),
    .VID_TRANSITION_DONE(vid_done), .CORE_POWER_GOOD_O(core_pg_o),
    .CORE_POWER_GOOD_OE_N(core_pg_oe_n), .NB_POWER_GOOD_O(nb_pg_o),
    .NB_POWER_GOOD_OE_N(nb_pg_oe_n), .TELEMETRY_LINE_O(tel_o),
    .TELEMETRY_LINE_OE_N(tel_oe_n));
  // ****************
  // Tasks
  // ****************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task timeout;
    fail_count++;
    end_sim;
  endtask
  // Outputs are looked at on the falling edge, away from their own updates.
  task tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task wait_bit(input int idx, input logic v, input int lim);
    n = 0;
    while (flags[idx] !== v)
    begin
      tick(1);
      n++;
      if (n > lim)
        timeout;
    end
  endtask
  task wait_mv(input logic [11:0] v, input int lim);
    n = 0;
    while (core_ref !== v)
    begin
      tick(1);
      n++;
      if (n > lim)
        timeout;
    end
  endtask
  task wait_ready;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge clk);
      if (++n > 50)
        timeout;
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    n = 0;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask
  task bring_up(input int c);
    boot = 1100 - 100 * c;
    plat_i.power_on(c[1:0]);
    wait_mv(boot[11:0], boot * 8 + 100);
    check(32'(n > boot * 8 - 40 && n < boot * 8 + 40), 1);
    check(nb_ref, boot[11:0]);
    check(ccm, 1'b1);
    tick(PG_DELAY_CYCLES - 100);
    check(core_pg_oe_n, 1'b0);
    wait_bit(F_CPG, 1'b1, 200);
    wait_bit(F_NPG, 1'b1, 10);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    #(40 * 90000);
    timeout;
  end
  initial
  begin
    code = $urandom(32'h32b3_9137);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    check({core_ref, core_pg_oe_n, nb_pg_oe_n, tel_oe_n}, 15'h0001);
    check({ccm, core_pg_o, nb_pg_o, tel_o}, 4'h1);
    check({hreadyout, hresp}, 2'b10);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, '0);
    check(rd, '0);
    for (int k = 0; k < 4; k++)
    begin
      plat_i.power_on(k[1:0]);
      tick(20);
      bus(1'b0, ADDR_STATUS, '0);
      check(rd[1:0], k[1:0]);
      check(rd[15:12], 4'h2);
      check(tel_oe_n, 1'b0);
      check(core_pg_oe_n | nb_pg_oe_n, 1'b0);
      plat_i.power_off();
      wait_bit(F_CSW, 1'b0, 2000);
    end
    tick(5);
    bus(1'b0, ADDR_STATUS, '0);
    check(rd[15:12], 4'h1);
    code = $urandom % 4;
    bring_up(code);
    plat_i.set_pok(1'b1);
    wait_bit(F_RUN, 1'b1, 100);
    check(tel_oe_n, 1'b1);
    tgt = boot + 1 + $urandom % 64;
    bus(1'b1, ADDR_COMMAND, 32'h0003_0000 | tgt);
    wait_bit(F_DONE, 1'b1, 700);
    check({core_ref, nb_ref}, {tgt[11:0], tgt[11:0]});
    check(core_pg_oe_n, 1'b1);
    plat_i.set_pok(1'b0);
    tick(4);
    check({vid_run, tel_oe_n}, 2'b00);
    wait_mv(boot[11:0], 700);
    bus(1'b1, ADDR_COMMAND, 32'h0001_0000 | (boot - 50));
    tick(500);
    bus(1'b0, ADDR_REFS, '0);
    check(rd, {4'h0, boot[11:0], 4'h0, boot[11:0]});
    plat_i.power_off();
    tick(3);
    check({core_pg_oe_n, nb_pg_oe_n}, 2'b00);
    tick(boot * 8 - 2000);
    check({core_sw, nb_sw}, 2'b11);
    wait_mv(12'h000, 2100);
    check(32'(n > 1960 && n < 2040), 1);
    wait_bit(F_CSW, 1'b0, 10);
    bring_up(3);
    @(posedge clk);
    core_trip <= trip_t'(3'b001 << ($urandom % 3));
    @(posedge clk);
    core_trip <= '0;
    tick(3);
    check(core_pg_oe_n, 1'b0);
    tick(CROSS_DELAY_CYCLES - 10);
    check(nb_pg_oe_n, 1'b1);
    wait_bit(F_NPG, 1'b0, 20);
    plat_i.power_off();
    wait_bit(F_CSW, 1'b0, 7000);
    bus(1'b0, ADDR_STATUS, '0);
    check(rd[7], 1'b1);
    @(posedge clk);
    drv_ok <= 1'b0;
    tick(3);
    @(posedge clk);
    drv_ok <= 1'b1;
    bus(1'b0, ADDR_STATUS, '0);
    check({rd[7], rd[1:0]}, 3'b000);
    plat_i.set_pok(1'b1);
    plat_i.power_on(2'b00);
    tick(200);
    bus(1'b0, ADDR_STATUS, '0);
    check({core_ref, vid_run, rd[9]}, 14'h0001);
    end_sim;
  end
endmodule
